/* rtl/oodt_timer.sv */
// on/off delay timer function block, top level
//
// Overview of operation
// - on-delay: each trigger rising edge restarts elapsed time from zero.
// - on-delay: output rises when trigger stayed high for the full delay.
// - on-delay: trigger falling early clears elapsed time; next edge restarts.
// - on-delay: output is low whenever trigger is low.
// - retentive: keep output and elapsed time over power loss; else defaults.
// - constant delay timebases: 99:99 s, 99:59 m, 99:59 h.
// - referenced value counts ms (max 99990), s or min (max 5999).
// - out-of-range referenced values saturate to the nearest limit.
// - delay comes from a constant or another block's live value by number.
// - off-delay: output rises at once with trigger high.
// - off-delay: trigger falling edge restarts elapsed time, output stays high unless the delay is zero.
// - off-delay: output falls when elapsed time equals the delay.
// - off-delay: a new trigger pulse retriggers elapsed time.
// - off-delay: clear zeroes elapsed time and drops output early.
`timescale 1ns/100ps
`default_nettype none
module oodt_timer #(
    parameter int TICK_FINE_CYC = oodt_pkg::TICK_FINE_CYC
) (
    input  wire logic                         ref_clk,
    input  wire logic                         rstn,
    input  wire logic                         trg,
    input  wire logic                         clr,
    input  wire oodt_pkg::oodt_mode_t         mode,
    input  wire logic                         retain_en,
    input  wire logic                         power_ok,
    input  wire logic                         use_ref,
    input  wire logic [oodt_pkg::SRC_SEL_W-1:0] src_sel,
    input  wire oodt_pkg::oodt_src_t [oodt_pkg::N_SRC-1:0] src_values,
    input  wire oodt_pkg::oodt_tb_t           tb,
    input  wire logic [oodt_pkg::CONST_W-1:0] const_hi,
    input  wire logic [oodt_pkg::CONST_W-1:0] const_lo,
    output var  logic                         q,
    output var  oodt_pkg::oodt_ticks_t        elapsed_time,
    output var  logic                         running
);
    import oodt_pkg::*;

    typedef struct packed {
        oodt_ticks_t elapsed;
        logic        q;
        logic        run;
        logic        trg_d;
        logic        pwr_d;
    } oodt_st_t;

    oodt_link_if lk ();

    oodt_st_t st;
    oodt_st_t next_st;
    logic     tick;
    logic     rise;
    logic     fall;

    //////////////////////////////////////////////////////////////////////
    oodt_tick_gen #(
        .FINE_CYC (TICK_FINE_CYC)
    ) u_tick (
        .ref_clk (ref_clk),
        .rstn    (rstn),
        .lk      (lk)
    );

    oodt_delay_sel u_dsel (
        .ref_clk    (ref_clk),
        .rstn       (rstn),
        .use_ref    (use_ref),
        .src_sel    (src_sel),
        .src_values (src_values),
        .tb         (tb),
        .const_hi   (const_hi),
        .const_lo   (const_lo),
        .lk         (lk)
    );

    //////////////////////////////////////////////////////////////////////
    // timebase tick for the active delay unit
    always_comb begin
        case (lk.tb)
            OODT_TB_FINE:   tick = lk.tick_fine;
            OODT_TB_MID:    tick = lk.tick_sec;
            OODT_TB_COARSE: tick = lk.tick_min;
            default:        tick = 1'b0;
        endcase
    end

    assign rise = trg && !st.trg_d;
    assign fall = !trg && st.trg_d;

    //////////////////////////////////////////////////////////////////////
    always_comb begin
        next_st       = st;
        next_st.pwr_d = power_ok;
        if (!power_ok) begin
            next_st = st;
            next_st.pwr_d = 1'b0;
        end else if (!st.pwr_d && !retain_en) begin
            next_st.elapsed = ET_ZERO;
            next_st.q       = 1'b0;
            next_st.run     = 1'b0;
            next_st.trg_d   = trg;
        end else begin
            next_st.trg_d = trg;
            case (mode)
                OODT_MODE_ON: begin
                    if (!trg) begin
                        next_st.elapsed = ET_ZERO;
                        next_st.run     = 1'b0;
                        next_st.q       = 1'b0;
                    end else if (rise) begin
                        next_st.elapsed = ET_ZERO;
                        next_st.run     = 1'b1;
                        next_st.q       = (lk.delay == ET_ZERO);
                    end else if (st.run) begin
                        if (st.elapsed >= lk.delay) begin
                            next_st.elapsed = lk.delay;
                            next_st.q       = 1'b1;
                            next_st.run     = 1'b0;
                        end else if (tick) begin
                            next_st.elapsed = st.elapsed + ET_ONE;
                            if (st.elapsed + ET_ONE >= lk.delay) begin
                                next_st.q   = 1'b1;
                                next_st.run = 1'b0;
                            end
                        end
                    end
                end
                OODT_MODE_OFF: begin
                    if (clr) begin
                        next_st.elapsed = ET_ZERO;
                        next_st.q       = 1'b0;
                        next_st.run     = 1'b0;
                    end else if (trg) begin
                        next_st.q       = 1'b1;
                        next_st.elapsed = ET_ZERO;
                        next_st.run     = 1'b0;
                    end else if (fall) begin
                        next_st.elapsed = ET_ZERO;
                        next_st.run     = 1'b1;
                        next_st.q       = (lk.delay != ET_ZERO);
                    end else if (st.run) begin
                        if (st.elapsed >= lk.delay) begin
                            next_st.elapsed = lk.delay;
                            next_st.q       = 1'b0;
                            next_st.run     = 1'b0;
                        end else if (tick) begin
                            next_st.elapsed = st.elapsed + ET_ONE;
                            if (st.elapsed + ET_ONE >= lk.delay) begin
                                next_st.q   = 1'b0;
                                next_st.run = 1'b0;
                            end
                        end
                    end
                end
                default: begin
                    next_st.elapsed = ET_ZERO;
                    next_st.q       = 1'b0;
                    next_st.run     = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            st <= '{elapsed: ET_ZERO, q: 1'b0, run: 1'b0, trg_d: 1'b0,
                    pwr_d: 1'b1};
        end else begin
            st <= next_st;
        end
    end

    //////////////////////////////////////////////////////////////////////
    assign q            = st.q;
    assign elapsed_time = st.elapsed;
    assign running      = st.run;
endmodule : oodt_timer
`default_nettype wire

/* shared/oodt_pkg.sv */
// shared constants, types and helpers of the on/off delay timer
package oodt_pkg;

    localparam int ET_W           = 14;
    localparam int SRC_W          = 32;
    localparam int N_SRC          = 8;
    localparam int SRC_SEL_W      = 3;
    localparam int CONST_W        = 7;

    localparam int CLK_PERIOD_NS  = 5;
    localparam int TICK_FINE_NS   = 10_000_000;
    localparam int TICK_FINE_CYC  = TICK_FINE_NS / CLK_PERIOD_NS;
    localparam int FINE_PER_SEC   = 100;
    localparam int SEC_PER_MIN    = 60;

    localparam int CONST_HI_MAX   = 99;
    localparam int CONST_LO_MAX_F = 99;
    localparam int CONST_LO_MAX_C = 59;
    localparam int HI_SCALE_F     = 100;
    localparam int HI_SCALE_C     = 60;

    localparam int REF_MS_MAX     = 99990;
    localparam int REF_MS_PER_TCK = 10;
    localparam int REF_SM_MAX     = 5999;
    localparam int VAL_MIN        = 0;

    typedef logic [ET_W-1:0] oodt_ticks_t;
    typedef logic signed [SRC_W-1:0] oodt_src_t;

    localparam oodt_ticks_t ET_ZERO = 14'h0000;
    localparam oodt_ticks_t ET_ONE  = 14'h0001;

    typedef enum logic [2:0] {
        OODT_TB_FINE   = 3'h1,
        OODT_TB_MID    = 3'h2,
        OODT_TB_COARSE = 3'h4
    } oodt_tb_t;

    typedef enum logic [1:0] {
        OODT_MODE_ON  = 2'h1,
        OODT_MODE_OFF = 2'h2
    } oodt_mode_t;

    function automatic int oodt_clamp(input int v, input int lo,
                                      input int hi);
        int r;
        r = v;
        if (v < lo) begin
            r = lo;
        end else if (v > hi) begin
            r = hi;
        end
        return r;
    endfunction : oodt_clamp

endpackage : oodt_pkg

/* shared/oodt_link_if.sv */
// timebase ticks and resolved delay passed to the timer core
`timescale 1ns/100ps
`default_nettype none
interface oodt_link_if;
    import oodt_pkg::*;
    logic        tick_fine;
    logic        tick_sec;
    logic        tick_min;
    oodt_ticks_t delay;
    oodt_tb_t    tb;

    modport tick_src (output tick_fine, output tick_sec, output tick_min);
    modport dly_src  (output delay, output tb);
    modport sink     (input tick_fine, input tick_sec, input tick_min,
                      input delay, input tb);
endinterface : oodt_link_if
`default_nettype wire

/* rtl/oodt_tick_gen.sv */
// periodic timebase tick generator: 10 ms, 1 s and 1 min pulses
`timescale 1ns/100ps
`default_nettype none
module oodt_tick_gen #(
    parameter int FINE_CYC = oodt_pkg::TICK_FINE_CYC
) (
    input  wire logic      ref_clk,
    input  wire logic      rstn,
    oodt_link_if.tick_src  lk
);
    import oodt_pkg::*;

    typedef struct packed {
        logic [31:0] cyc;
        logic [6:0]  fine;
        logic [5:0]  sec;
        logic        t_fine;
        logic        t_sec;
        logic        t_min;
    } oodt_tg_t;

    localparam logic [31:0] CYC_LAST  = 32'(FINE_CYC - 1);
    localparam logic [6:0]  FINE_LAST = 7'(FINE_PER_SEC - 1);
    localparam logic [5:0]  SEC_LAST  = 6'(SEC_PER_MIN - 1);

    oodt_tg_t st;
    oodt_tg_t next_st;

    //////////////////////////////////////////////////////////////////////
    always_comb begin
        next_st        = st;
        next_st.t_fine = 1'b0;
        next_st.t_sec  = 1'b0;
        next_st.t_min  = 1'b0;
        if (st.cyc >= CYC_LAST) begin
            next_st.cyc    = 32'h00000000;
            next_st.t_fine = 1'b1;
            if (st.fine == FINE_LAST) begin
                next_st.fine  = 7'h00;
                next_st.t_sec = 1'b1;
                if (st.sec == SEC_LAST) begin
                    next_st.sec   = 6'h00;
                    next_st.t_min = 1'b1;
                end else begin
                    next_st.sec = st.sec + 6'h01;
                end
            end else begin
                next_st.fine = st.fine + 7'h01;
            end
        end else begin
            next_st.cyc = st.cyc + 32'h00000001;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign lk.tick_fine = st.t_fine;
    assign lk.tick_sec  = st.t_sec;
    assign lk.tick_min  = st.t_min;
endmodule : oodt_tick_gen
`default_nettype wire

/* rtl/oodt_delay_sel.sv */
// delay source select, range clamp and conversion to ticks
`timescale 1ns/100ps
`default_nettype none
module oodt_delay_sel (
    input  wire logic                         ref_clk,
    input  wire logic                         rstn,
    input  wire logic                         use_ref,
    input  wire logic [oodt_pkg::SRC_SEL_W-1:0] src_sel,
    input  wire oodt_pkg::oodt_src_t [oodt_pkg::N_SRC-1:0] src_values,
    input  wire oodt_pkg::oodt_tb_t           tb,
    input  wire logic [oodt_pkg::CONST_W-1:0] const_hi,
    input  wire logic [oodt_pkg::CONST_W-1:0] const_lo,
    oodt_link_if.dly_src                      lk
);
    import oodt_pkg::*;

    typedef struct packed {
        oodt_ticks_t delay;
        oodt_tb_t    tb;
    } oodt_ds_t;

    oodt_ds_t st;
    oodt_ds_t next_st;

    //////////////////////////////////////////////////////////////////////
    always_comb begin
        int v;
        int hi;
        int lo;
        v       = 0;
        hi      = 0;
        lo      = 0;
        next_st = st;
        next_st.tb = tb;
        if (use_ref) begin
            v = int'(src_values[src_sel]);
            if (tb == OODT_TB_FINE) begin
                v = oodt_clamp(v, VAL_MIN, REF_MS_MAX) / REF_MS_PER_TCK;
            end else begin
                v = oodt_clamp(v, VAL_MIN, REF_SM_MAX);
            end
        end else begin
            hi = oodt_clamp(int'(const_hi), VAL_MIN, CONST_HI_MAX);
            if (tb == OODT_TB_FINE) begin
                lo = oodt_clamp(int'(const_lo), VAL_MIN, CONST_LO_MAX_F);
                v  = hi * HI_SCALE_F + lo;
            end else begin
                lo = oodt_clamp(int'(const_lo), VAL_MIN, CONST_LO_MAX_C);
                v  = hi * HI_SCALE_C + lo;
            end
        end
        next_st.delay = v[ET_W-1:0];
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            st <= '{delay: ET_ZERO, tb: OODT_TB_FINE};
        end else begin
            st <= next_st;
        end
    end

    assign lk.delay = st.delay;
    assign lk.tb    = st.tb;
endmodule : oodt_delay_sel
`default_nettype wire

/* testbench/oodt_timer_chk.sv */
// assertion checker of the on/off delay timer ports
`timescale 1ns/100ps
`default_nettype none
module oodt_timer_chk (
    input wire logic                  ref_clk,
    input wire logic                  rstn,
    input wire logic                  trg,
    input wire logic                  clr,
    input wire oodt_pkg::oodt_mode_t  mode,
    input wire logic                  power_ok,
    input wire logic                  q,
    input wire oodt_pkg::oodt_ticks_t elapsed_time,
    input wire logic                  running
);
    import oodt_pkg::*;
    logic on_m;
    logic off_m;
    assign on_m  = power_ok && mode == OODT_MODE_ON;
    assign off_m = power_ok && mode == OODT_MODE_OFF;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    ////////////////////////////////////////////////////////////////////////
    AST_ON_RISE:
        assert property (on_m && $rose(trg) |=> elapsed_time == ET_ZERO)
        else $error("elapsed time not restarted on trigger rise");
    AST_ON_LOW:
        assert property (on_m && !trg |=>
            !q && !running && elapsed_time == ET_ZERO)
        else $error("on-delay state not cleared while trigger low");
    AST_OFF_SET:
        assert property (off_m && trg && !clr |=>
            q && !running && elapsed_time == ET_ZERO)
        else $error("off-delay output not set by trigger");
    AST_OFF_FALL:
        assert property (off_m && !clr && $fell(trg) |=>
            elapsed_time == ET_ZERO && (running || !q))
        else $error("off-delay not restarted on trigger fall");
    AST_OFF_CLR:
        assert property (off_m && clr |=>
            !q && !running && elapsed_time == ET_ZERO)
        else $error("clear did not drop output and time");
    AST_STEP:
        assert property ($changed(elapsed_time) && elapsed_time != ET_ZERO
            |-> elapsed_time == $past(elapsed_time) + ET_ONE)
        else $error("elapsed time stepped by more than one");
    AST_FROZEN:
        assert property (!power_ok |=> $stable(q) && $stable(running)
            && $stable(elapsed_time))
        else $error("state changed while power lost");
    AST_Q_SRC:
        assert property ($rose(q) |-> $past(trg))
        else $error("output rose without trigger");
    ////////////////////////////////////////////////////////////////////////
    COV_ON_Q: cover property (on_m && $rose(q));
    COV_OFF_EXP: cover property (off_m && !clr && $fell(q));
    COV_POWER: cover property (!power_ok ##1 power_ok);
endmodule : oodt_timer_chk
bind oodt_timer oodt_timer_chk u_chk (.ref_clk, .rstn, .trg, .clr, .mode,
    .power_ok, .q, .elapsed_time, .running);
`default_nettype wire

/* testbench/oodt_timer_test.sv */
// self-checking bench of the on/off delay timer
`timescale 1ns/100ps
`default_nettype none
module oodt_timer_test;
    import oodt_pkg::*;
    logic                  ref_clk, rstn, trg, clr, retain_en, power_ok;
    logic                  use_ref, q, running;
    logic [SRC_SEL_W-1:0]  src_sel;
    oodt_src_t [N_SRC-1:0] sv;
    oodt_tb_t              tb;
    oodt_mode_t            mode;
    logic [CONST_W-1:0]    c_hi, c_lo;
    oodt_ticks_t           et, saved;
    int                    num_errors, checks;

    oodt_timer #(.TICK_FINE_CYC(4)) dut (.ref_clk, .rstn, .trg, .clr, .mode,
        .retain_en, .power_ok, .use_ref, .src_sel, .src_values(sv), .tb,
        .const_hi(c_hi), .const_lo(c_lo), .q, .elapsed_time(et), .running);

    always #2.5 ref_clk = ~ref_clk;
    ////////////////////////////////////////////////////////////////////////
    task automatic test_done;
        if (num_errors == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : test_done

    task automatic step(input int n);
        repeat (n) begin
            @(posedge ref_clk);
            #1;
        end
    endtask : step

    task automatic chk(input string nm, input int e, input oodt_ticks_t g);
        checks++;
        if (g !== 14'(e)) begin
            num_errors++;
            $display("mismatch %s expected %0d seen %0d", nm, e, g);
        end
    endtask : chk

    task automatic wait_q(input logic v, input int n);
        for (int i = 0; i < n && q !== v; i++) step(1);
        chk("q", int'(v), oodt_ticks_t'(q));
    endtask : wait_q

    task automatic cfg(input logic r, input oodt_tb_t b,
                       input logic [6:0] h, input logic [6:0] l);
        use_ref = r;
        tb = b;
        c_hi = h;
        c_lo = l;
        step(2);
    endtask : cfg

    // on-delay run of d ticks, tick period per cycles
    task automatic run_on(input int d, input int per);
        mode = OODT_MODE_ON;
        trg = 1;
        step(1);
        if (d > 0) begin
            step(per * d - per);
            chk("q early", 0, q);
            wait_q(1, per + 2);
        end else begin
            chk("q", 1, q);
        end
        chk("elapsed", d, et);
        trg = 0;
        step(1);
        chk("q low", 0, q);
        chk("elapsed", 0, et);
    endtask : run_on
    ////////////////////////////////////////////////////////////////////////
    initial begin
        ref_clk = 0; rstn = 0; trg = 0; clr = 0; retain_en = 0;
        power_ok = 1; use_ref = 0; src_sel = 3'h3; sv = '0;
        tb = OODT_TB_FINE; mode = OODT_MODE_ON; c_hi = 7'h00; c_lo = 7'h05;
        num_errors = 0; checks = 0;
        repeat (20) @(posedge ref_clk);
        #1 rstn = 1;
        step(2);
        run_on(5, 4);
        trg = 1;
        step(10);
        trg = 0;
        step(2);
        run_on(5, 4);
        // off-delay: retrigger, expiry, clear
        mode = OODT_MODE_OFF;
        trg = 1;
        step(1);
        chk("q set", 1, q);
        trg = 0;
        step(8);
        chk("q hold", 1, q);
        trg = 1;
        step(1);
        chk("elapsed", 0, et);
        trg = 0;
        step(17);
        chk("q hold", 1, q);
        chk("running", 1, running);
        wait_q(0, 6);
        chk("elapsed", 5, et);
        step(8);
        chk("elapsed sat", 5, et);
        trg = 1;
        clr = 1;
        step(1);
        chk("q clr", 0, q);
        clr = 0;
        step(1);
        chk("q set", 1, q);
        trg = 0;
        step(8);
        clr = 1;
        step(1);
        chk("q clr", 0, q);
        chk("elapsed", 0, et);
        clr = 0;
        // referenced and constant delays over all timebases
        sv[3] = 32'h00000032;
        cfg(1, OODT_TB_FINE, 7'h00, 7'h00);
        run_on(5, 4);
        sv[3] = 32'hFFFFFFF9;
        cfg(1, OODT_TB_FINE, 7'h00, 7'h00);
        run_on(0, 4);
        sv[5] = 32'h00000002;
        src_sel = 3'h5;
        cfg(1, OODT_TB_MID, 7'h00, 7'h00);
        run_on(2, 400);
        src_sel = 3'h3;
        sv[3] = 32'h000186A0;
        cfg(1, OODT_TB_FINE, 7'h00, 7'h00);
        run_on(9999, 4);
        cfg(0, OODT_TB_COARSE, 7'h00, 7'h01);
        run_on(1, 24000);
        cfg(0, OODT_TB_FINE, 7'h00, 7'h7F);
        run_on(99, 4);
        // power loss with and without retention
        mode = OODT_MODE_OFF;
        trg = 1;
        step(1);
        trg = 0;
        retain_en = 1;
        step(10);
        power_ok = 0;
        step(1);
        saved = et;
        step(20);
        chk("elapsed frozen", int'(saved), et);
        power_ok = 1;
        step(1);
        chk("q kept", 1, q);
        retain_en = 0;
        power_ok = 0;
        step(2);
        power_ok = 1;
        step(1);
        chk("q reload", 0, q);
        chk("elapsed reload", 0, et);
        test_done;
    end

    initial begin
        #(5 * 90000);
        num_errors++;
        test_done;
    end
endmodule : oodt_timer_test
`default_nettype wire
